// file: frame_dma_pkg.sv
package frame_dma_pkg;
	// channel map
	localparam int NCH = 8;
	localparam logic [2:0] XTR_CH0 = 3'h6;
	// register byte offsets
	localparam logic [7:0] OFF_ACTIVATE = 8'h00;
	localparam logic [7:0] OFF_RELIST = 8'h04;
	localparam logic [7:0] OFF_STOP = 8'h08;
	localparam logic [7:0] OFF_FORCE = 8'h0c;
	localparam logic [7:0] OFF_ACTIVE = 8'h10;
	localparam logic [7:0] OFF_PENDING = 8'h14;
	localparam logic [7:0] OFF_EV_DCB = 8'h18;
	localparam logic [7:0] OFF_EV_DB = 8'h1c;
	localparam logic [7:0] OFF_EV_ERR = 8'h20;
	localparam logic [7:0] OFF_EN_DCB = 8'h24;
	localparam logic [7:0] OFF_EN_DB = 8'h28;
	localparam logic [7:0] OFF_EN_CH = 8'h2c;
	localparam logic [7:0] OFF_VECTOR = 8'h30;
	// per-channel arrays, selected by address bits 7:5
	localparam logic [2:0] GRP_HEAD = 3'h2;
	localparam logic [2:0] GRP_CUR = 3'h3;
	localparam logic [2:0] GRP_CFG = 3'h4;
	// channel config fields
	localparam int CFG_NDB_LSB = 0;
	localparam int CFG_EOF_ONLY = 4;
	localparam int CFG_INJ_PORT = 5;
	localparam logic [5:0] CFG_RESET = 6'h0f;
	// block_word_a fields
	localparam int BLOCK_WORD_A_SIZE_LSB = 0;
	localparam int BLOCK_WORD_A_NOTIFY = 16;
	// status word fields
	localparam int ST_LEN_LSB = 0;
	localparam int ST_SOF = 16;
	localparam int ST_EOF = 17;
	localparam int ST_NOTIFY = 18;
	localparam int ST_DONE = 19;
	localparam int ST_OFF_LSB = 20;
	// reorder buffer layout
	localparam logic [5:0] DATA_TAG0 = 6'h20;
	localparam logic [4:0] BATCH = 5'h10;
	typedef enum {S_IDLE, S_FETCH, S_ENTRY, S_INJ, S_XTR, S_WB, S_RELIST, S_DRAIN} eng_state_t;
endpackage : frame_dma_pkg

// file: frame_dma_engine.sv
// Notes on behaviour
// - block: next pointer, word a, pairs
// - one frame per block, start/end flags
// - out-of-order fetches restored to order
// - extraction ignores offset, computes length
// - entries in order, stop at invalid
// - invalid: misaligned xtr, zero inj length
// - misaligned next pointer ends chain
// - head pointer then activate starts fetching
// - stop request finishes ongoing fetch first
// - force stop deactivates at once
// - fetched blocks still processed after stop
// - inactive, active pending, active idle
// - write back status with done set
// - notify in word a sets event
// - notify in status sets block event
// - errors always reach channel interrupt
// - enabled channels form vector, irq
// - channels 6,7 extract, others inject
// - extraction first, higher number wins
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module frame_dma_engine
	import frame_dma_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [63:0] mem_wdata,
	output logic [5:0] mem_tag,
	input wire logic mem_gnt,
	input wire logic mem_rvalid,
	input wire logic [5:0] mem_rtag,
	input wire logic [63:0] mem_rdata,
	input wire logic mem_rerr,
	output logic inj_valid,
	input wire logic inj_ready,
	output logic [63:0] inj_data,
	output logic [7:0] inj_byte_en,
	output logic inj_sof,
	output logic inj_eof,
	output logic inj_port,
	input wire logic xtr_valid,
	input wire logic xtr_port,
	input wire logic [63:0] xtr_data,
	input wire logic xtr_last,
	input wire logic [2:0] xtr_bytes,
	output logic xtr_ready,
	output logic irq
);

	typedef struct packed {
		eng_state_t st;
		logic [7:0] active;
		logic [7:0] ended;
		logic [7:0] reload;
		logic [7:0] stop;
		logic [7:0] ev_dcb;
		logic [7:0] ev_db;
		logic [7:0] ev_err;
		logic [7:0] en_dcb;
		logic [7:0] en_db;
		logic [7:0] en_ch;
		logic [1:0] sof_next;
		logic [7:0][31:0] llp;
		logic [7:0][31:0] prev;
		logic [7:0][5:0] cfg;
		logic [63:0][63:0] rob;
		logic [63:0] got;
		logic [6:0] outst;
		logic [2:0] cur;
		logic [31:0] base;
		logic [15:0] bsize;
		logic [3:0] idx;
		logic [31:0] dptr;
		logic [31:0] dst;
		logic [5:0] iss;
		logic [4:0] bi;
		logic [4:0] bo;
		logic [4:0] bn;
		logic [15:0] k;
		logic [15:0] nbytes;
		logic ap_we;
		logic [7:0] ap_addr;
		logic [31:0] rdata;
	} state_t;

	state_t s_q, s_d;

	// words covering an injection block from its aligned start
	function automatic logic [15:0] tot_words(input logic [31:0] st);
		logic [18:0] sum;
		sum = {3'h0, st[ST_LEN_LSB +: 16]} + {16'h0, st[ST_OFF_LSB +: 3]} + 19'h7;
		return sum[18:3];
	endfunction : tot_words

	// next batch length, at most BATCH words
	function automatic logic [4:0] batch_len(input logic [15:0] rem);
		return (rem > {11'h0, BATCH}) ? BATCH : rem[4:0];
	endfunction : batch_len

	// byte lanes of word k that carry frame data
	function automatic logic [7:0] lane_mask(input logic [15:0] k, input logic [31:0] st);
		logic [18:0] pos;
		logic [18:0] lo;
		logic [18:0] hi;
		lane_mask = 8'h00;
		lo = {16'h0, st[ST_OFF_LSB +: 3]};
		hi = lo + {3'h0, st[ST_LEN_LSB +: 16]};
		for (int j = 0; j < 8; j++)
		begin
			pos = {k, 3'h0} + 19'(j);
			lane_mask[j] = (pos >= lo) && (pos < hi);
		end
	endfunction : lane_mask

	// highest pending channel; 7,6 extract so they lead
	function automatic logic [2:0] pick(input logic [7:0] pend);
		pick = 3'h0;
		for (int c = 0; c < NCH; c++)
			if (pend[c])
				pick = 3'(c);
	endfunction : pick

	logic [7:0] act_w, rel_w, stp_w, frc_w, clr_dcb, clr_db, clr_err;
	logic [7:0] pend, vec;
	logic [5:0] nw;
	logic [31:0] fmask;
	logic [5:0] ent;
	logic [15:0] tot;
	logic is_xtr, busy_fetch, fin, rd_take;
	logic [31:0] wb;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;

	// pending state and interrupt vector
	always_comb
	begin
		pend = s_q.active & ~s_q.stop & (~s_q.ended | s_q.reload);
		vec = s_q.en_ch & (s_q.ev_err | (s_q.ev_dcb & s_q.en_dcb)
			| (s_q.ev_db & s_q.en_db));
		irq = |vec;
	end

	// next state of the whole block
	always_comb
	begin
		s_d = s_q;
		mem_req = 1'b0;
		mem_we = 1'b0;
		mem_addr = 32'h0;
		mem_wdata = 64'h0;
		mem_tag = 6'h0;
		inj_valid = 1'b0;
		inj_data = s_q.rob[DATA_TAG0 + 6'(s_q.bo)];
		inj_byte_en = lane_mask(s_q.k, s_q.dst);
		inj_sof = 1'b0;
		inj_eof = 1'b0;
		inj_port = s_q.cfg[s_q.cur][CFG_INJ_PORT];
		xtr_ready = 1'b0;
		rd_take = 1'b0;
		act_w = 8'h0;
		rel_w = 8'h0;
		stp_w = 8'h0;
		frc_w = 8'h0;
		clr_dcb = 8'h0;
		clr_db = 8'h0;
		clr_err = 8'h0;
		nw = 6'h2 + {1'b0, s_q.cfg[s_q.cur][CFG_NDB_LSB +: 4], 1'b0};
		fmask = 32'hffffffff >> (6'd32 - nw);
		ent = {1'b0, s_q.idx, 1'b0} + 6'h2;
		tot = tot_words(s_q.dst);
		is_xtr = s_q.cur >= XTR_CH0;
		busy_fetch = (s_q.st == S_FETCH) || (s_q.st == S_RELIST);
		fin = 1'b0;
		wb = 32'h0;

		// bus data phase write
		s_d.ap_we = 1'b0;
		if (s_q.ap_we)
		begin
			unique case (s_q.ap_addr)
				OFF_ACTIVATE: act_w = hwdata[7:0];
				OFF_RELIST: rel_w = hwdata[7:0];
				OFF_STOP: stp_w = hwdata[7:0];
				OFF_FORCE: frc_w = hwdata[7:0];
				OFF_EV_DCB: clr_dcb = hwdata[7:0];
				OFF_EV_DB: clr_db = hwdata[7:0];
				OFF_EV_ERR: clr_err = hwdata[7:0];
				OFF_EN_DCB: s_d.en_dcb = hwdata[7:0];
				OFF_EN_DB: s_d.en_db = hwdata[7:0];
				OFF_EN_CH: s_d.en_ch = hwdata[7:0];
				default:
				begin
					if (s_q.ap_addr[7:5] == GRP_HEAD)
						s_d.llp[s_q.ap_addr[4:2]] = hwdata;
					if (s_q.ap_addr[7:5] == GRP_CFG)
						s_d.cfg[s_q.ap_addr[4:2]] = hwdata[5:0];
				end
			endcase
		end
		s_d.ev_dcb = s_q.ev_dcb & ~clr_dcb;
		s_d.ev_db = s_q.ev_db & ~clr_db;
		s_d.ev_err = s_q.ev_err & ~clr_err;

		// channel control bits
		for (int c = 0; c < NCH; c++)
		begin
			if (act_w[c])
			begin
				if (s_q.llp[c][2:0] == 3'h0)
				begin
					s_d.active[c] = 1'b1;
					s_d.ended[c] = 1'b0;
					s_d.stop[c] = 1'b0;
					s_d.reload[c] = 1'b0;
				end
				else
					s_d.ev_err[c] = 1'b1;
			end
			if (rel_w[c] && s_q.active[c])
				s_d.reload[c] = 1'b1;
			if (stp_w[c] && s_q.active[c])
				s_d.stop[c] = 1'b1;
			if (s_q.stop[c] && !(busy_fetch && s_q.cur == 3'(c)))
			begin
				s_d.active[c] = 1'b0;
				s_d.stop[c] = 1'b0;
				s_d.reload[c] = 1'b0;
			end
			if (frc_w[c])
			begin
				s_d.active[c] = 1'b0;
				s_d.stop[c] = 1'b0;
				s_d.reload[c] = 1'b0;
			end
		end

		// read responses land by tag, any order
		if (mem_rvalid)
		begin
			s_d.rob[mem_rtag] = mem_rdata;
			s_d.got[mem_rtag] = 1'b1;
			if (mem_rerr)
				s_d.ev_err[s_q.cur] = 1'b1;
		end

		// engine sequence
		unique case (s_q.st)
			S_IDLE:
			begin
				if (|pend)
				begin
					s_d.cur = pick(pend);
					if (!rel_w[pick(pend)])
						s_d.reload[pick(pend)] = 1'b0; // a relist written now still wins
					s_d.iss = 6'h0;
					s_d.got[31:0] = 32'h0;
					s_d.base = s_q.ended[pick(pend)] ? s_q.prev[pick(pend)] : s_q.llp[pick(pend)];
					s_d.st = s_q.ended[pick(pend)] ? S_RELIST : S_FETCH;
				end
			end
			S_FETCH:
			begin
				if (s_q.iss < nw)
				begin
					mem_req = 1'b1;
					mem_addr = s_q.base + {23'h0, s_q.iss, 3'h0};
					mem_tag = s_q.iss;
					rd_take = mem_gnt;
					if (mem_gnt)
						s_d.iss = s_q.iss + 6'h1;
				end
				else if ((s_q.got[31:0] & fmask) == fmask)
				begin
					s_d.prev[s_q.cur] = s_q.base;
					if (s_q.rob[0][2:0] != 3'h0)
						s_d.ended[s_q.cur] = 1'b1;
					else
						s_d.llp[s_q.cur] = s_q.rob[0][31:0];
					if (s_q.rob[1][BLOCK_WORD_A_NOTIFY])
						s_d.ev_dcb[s_q.cur] = 1'b1;
					s_d.bsize = s_q.rob[1][BLOCK_WORD_A_SIZE_LSB +: 16];
					s_d.idx = 4'h0;
					s_d.st = S_ENTRY;
				end
				if (frc_w[s_q.cur])
					s_d.st = S_DRAIN;
			end
			S_RELIST:
			begin
				if (s_q.iss == 6'h0)
				begin
					mem_req = 1'b1;
					mem_addr = s_q.base;
					rd_take = mem_gnt;
					if (mem_gnt)
						s_d.iss = 6'h1;
				end
				else if (s_q.got[0])
				begin
					if (s_q.rob[0][2:0] == 3'h0)
					begin
						s_d.llp[s_q.cur] = s_q.rob[0][31:0];
						s_d.ended[s_q.cur] = 1'b0;
					end
					s_d.st = S_IDLE;
				end
				if (frc_w[s_q.cur])
					s_d.st = S_DRAIN;
			end
			S_DRAIN:
			begin
				if (s_q.outst == 7'h0)
					s_d.st = S_IDLE;
			end
			S_ENTRY:
			begin
				s_d.dptr = s_q.rob[ent][31:0];
				s_d.dst = s_q.rob[ent + 6'h1][31:0];
				s_d.k = 16'h0;
				s_d.nbytes = 16'h0;
				s_d.bi = 5'h0;
				s_d.bo = 5'h0;
				s_d.bn = batch_len(tot_words(s_q.rob[ent + 6'h1][31:0]));
				s_d.got[47:32] = 16'h0;
				if (s_q.idx >= s_q.cfg[s_q.cur][CFG_NDB_LSB +: 4])
					s_d.st = S_IDLE;
				else if (is_xtr)
					s_d.st = (s_q.rob[ent][2:0] != 3'h0) ? S_IDLE : S_XTR;
				else
					s_d.st = (s_q.rob[ent + 6'h1][ST_LEN_LSB +: 16] == 16'h0) ? S_IDLE : S_INJ;
			end
			S_INJ:
			begin
				if (s_q.bi < s_q.bn)
				begin
					mem_req = 1'b1;
					mem_addr = {s_q.dptr[31:3], 3'h0}
						+ {13'h0, s_q.k - {11'h0, s_q.bo} + {11'h0, s_q.bi}, 3'h0};
					mem_tag = DATA_TAG0 + {1'b0, s_q.bi};
					rd_take = mem_gnt;
					if (mem_gnt)
						s_d.bi = s_q.bi + 5'h1;
				end
				if (s_q.bo < s_q.bn && s_q.got[DATA_TAG0 + 6'(s_q.bo)])
				begin
					inj_valid = 1'b1;
					inj_sof = s_q.dst[ST_SOF] && (s_q.k == 16'h0);
					inj_eof = s_q.dst[ST_EOF] && (s_q.k == tot - 16'h1);
					if (inj_ready)
					begin
						s_d.bo = s_q.bo + 5'h1;
						s_d.k = s_q.k + 16'h1;
					end
				end
				else if (s_q.bo == s_q.bn)
				begin
					if (s_q.k == tot)
						s_d.st = S_WB;
					else
					begin
						s_d.bn = batch_len(tot - s_q.k);
						s_d.bi = 5'h0;
						s_d.bo = 5'h0;
						s_d.got[47:32] = 16'h0;
					end
				end
			end
			S_XTR:
			begin
				if (xtr_port == s_q.cur[0])
				begin
					mem_req = xtr_valid;
					mem_we = 1'b1;
					mem_addr = s_q.dptr + {13'h0, s_q.k, 3'h0};
					mem_wdata = xtr_data;
					xtr_ready = mem_gnt;
					if (xtr_valid && mem_gnt)
					begin
						fin = xtr_last || ({s_q.k + 16'h1, 3'h0} >= {3'h0, s_q.bsize});
						s_d.k = s_q.k + 16'h1;
						s_d.nbytes = s_q.nbytes + ((xtr_last && xtr_bytes != 3'h0)
							? {13'h0, xtr_bytes} : 16'h8);
						s_d.dst[ST_SOF] = s_q.sof_next[s_q.cur[0]];
						s_d.dst[ST_EOF] = xtr_last;
						if (fin)
						begin
							s_d.sof_next[s_q.cur[0]] = xtr_last;
							s_d.st = S_WB;
						end
					end
				end
			end
			S_WB:
			begin
				wb = s_q.dst;
				if (is_xtr)
				begin
					wb[ST_LEN_LSB +: 16] = s_q.nbytes;
					wb[31:ST_OFF_LSB] = '0;
				end
				wb[ST_DONE] = 1'b1;
				mem_req = 1'b1;
				mem_we = 1'b1;
				mem_addr = s_q.base + {23'h0, ent + 6'h1, 3'h0};
				mem_wdata = {32'h0, wb};
				if (mem_gnt)
				begin
					if (s_q.dst[ST_NOTIFY] && (!s_q.cfg[s_q.cur][CFG_EOF_ONLY] || s_q.dst[ST_EOF]))
						s_d.ev_db[s_q.cur] = 1'b1;
					s_d.idx = s_q.idx + 4'h1;
					s_d.st = S_ENTRY;
				end
			end
		endcase

		s_d.outst = s_q.outst + {6'h0, rd_take} - {6'h0, mem_rvalid};

		// bus address phase capture and read mux
		if (hsel && hready && htrans[1])
		begin
			s_d.ap_we = hwrite;
			s_d.ap_addr = haddr[7:0];
			s_d.rdata = 32'h0;
			unique case (haddr[7:0])
				OFF_ACTIVE: s_d.rdata = {24'h0, s_d.active};
				OFF_PENDING: s_d.rdata = {24'h0, pend};
				OFF_EV_DCB: s_d.rdata = {24'h0, s_d.ev_dcb};
				OFF_EV_DB: s_d.rdata = {24'h0, s_d.ev_db};
				OFF_EV_ERR: s_d.rdata = {24'h0, s_d.ev_err};
				OFF_EN_DCB: s_d.rdata = {24'h0, s_d.en_dcb};
				OFF_EN_DB: s_d.rdata = {24'h0, s_d.en_db};
				OFF_EN_CH: s_d.rdata = {24'h0, s_d.en_ch};
				OFF_VECTOR: s_d.rdata = {24'h0, vec};
				default:
				begin
					if (haddr[7:5] == GRP_HEAD)
						s_d.rdata = s_d.llp[haddr[4:2]];
					if (haddr[7:5] == GRP_CUR)
						s_d.rdata = s_d.prev[haddr[4:2]];
					if (haddr[7:5] == GRP_CFG)
						s_d.rdata = {26'h0, s_d.cfg[haddr[4:2]]};
				end
			endcase
		end
	end

	// state register with synchronous reset
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s_q <= '0;
			s_q.st <= S_IDLE;
			s_q.sof_next <= 2'h3;
			s_q.cfg <= {NCH{CFG_RESET}};
		end
		else
			s_q <= s_d;
	end

endmodule : frame_dma_engine
`default_nettype wire

// file: frame_dma_engine_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module frame_dma_engine_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [63:0] mem_wdata,
	input wire logic [5:0] mem_tag,
	input wire logic mem_gnt,
	input wire logic inj_valid,
	input wire logic inj_ready,
	input wire logic [63:0] inj_data,
	input wire logic [7:0] inj_byte_en,
	input wire logic inj_sof,
	input wire logic inj_eof,
	input wire logic xtr_valid,
	input wire logic xtr_ready,
	input wire logic xtr_last,
	input wire logic [63:0] xtr_data,
	input wire logic irq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// last extracted word taken
	sequence xtr_end;
		xtr_valid && xtr_ready && xtr_last;
	endsequence
	// status write with done set and zero offset
	sequence status_wr;
		mem_req && mem_gnt && mem_we && mem_wdata[19] && mem_wdata[31:20] == 12'h0;
	endsequence
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not zero-wait okay");
	reset_quiet_a: assert property (disable iff (1'b0) rst |=> !mem_req && !inj_valid && !irq)
		else $error("outputs active after reset");
	mem_hold_a: assert property (mem_req && !mem_gnt |=> mem_req && $stable(mem_addr)
		&& $stable(mem_we) && $stable(mem_tag) && $stable(mem_wdata))
		else $error("memory request changed before grant");
	tag_range_a: assert property (mem_req && !mem_we |-> mem_tag <= 6'h2f)
		else $error("read tag out of range");
	inj_hold_a: assert property (inj_valid && !inj_ready |=> inj_valid && $stable(inj_data)
		&& $stable(inj_byte_en) && $stable(inj_sof) && $stable(inj_eof))
		else $error("injected word changed before ready");
	inj_bytes_a: assert property (inj_valid |-> inj_byte_en != 8'h0)
		else $error("empty injected word");
	xtr_write_a: assert property (xtr_valid && xtr_ready |-> mem_req && mem_we && mem_gnt
		&& mem_wdata == xtr_data)
		else $error("extracted word not written");
	status_after_a: assert property (xtr_end |-> ##[1:64] status_wr)
		else $error("no status write after frame end");
endmodule : frame_dma_engine_chk
bind frame_dma_engine frame_dma_engine_chk u_chk (.mclk, .rst, .hreadyout, .hresp, .mem_req,
	.mem_we, .mem_addr, .mem_wdata, .mem_tag, .mem_gnt, .inj_valid, .inj_ready, .inj_data,
	.inj_byte_en, .inj_sof, .inj_eof, .xtr_valid, .xtr_ready, .xtr_last, .xtr_data, .irq);
`default_nettype wire

// file: frame_dma_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module frame_dma_far_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic slow,
	input wire logic xtr_go,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [63:0] mem_wdata,
	input wire logic [5:0] mem_tag,
	output logic mem_gnt,
	output logic mem_rvalid,
	output logic [5:0] mem_rtag,
	output logic [63:0] mem_rdata,
	output logic mem_rerr,
	input wire logic inj_valid,
	output logic inj_ready,
	input wire logic [63:0] inj_data,
	input wire logic [7:0] inj_byte_en,
	input wire logic inj_sof,
	input wire logic inj_eof,
	input wire logic inj_port,
	output logic xtr_valid,
	output logic xtr_port,
	output logic [63:0] xtr_data,
	output logic xtr_last,
	output logic [2:0] xtr_bytes,
	input wire logic xtr_ready
);
	logic [63:0] mem [logic [28:0]];
	logic [37:0] pend [$];
	logic [74:0] inj_log [$];
	logic [37:0] r;
	logic ph;
	// memory: grant, store writes, answer reads newest first
	always @(posedge mclk)
	begin
		ph <= rst ? 1'b0 : ~ph;
		mem_gnt <= !slow || ph;
		inj_ready <= !slow || !ph;
		mem_rvalid <= 1'b0;
		mem_rerr <= 1'b0;
		mem_rdata <= ~mem_rdata; // idle data keeps moving
		mem_rtag <= ~mem_rtag;
		if (rst)
		begin
			pend.delete();
			mem_rdata <= 64'h0;
			mem_rtag <= 6'h0;
		end
		else if (mem_req && mem_gnt && mem_we)
			mem[mem_addr[31:3]] = mem_wdata;
		else if (mem_req && mem_gnt)
			pend.push_back({mem_tag, mem_addr});
		if (!rst && (pend.size() > 1 || (pend.size() == 1 && ph)))
		begin
			r = pend.pop_back(); // out of order
			mem_rvalid <= 1'b1;
			mem_rtag <= r[37:32];
			mem_rdata <= mem.exists(r[31:3]) ? mem[r[31:3]] : 64'h0;
		end
	end
	// switch side: log injected words, send one two-word frame
	always @(posedge mclk)
	begin
		if (inj_valid && inj_ready && !rst)
			inj_log.push_back({inj_port, inj_sof, inj_eof, inj_byte_en, inj_data});
		if (rst)
		begin
			xtr_valid <= 1'b0;
			xtr_last <= 1'b0;
			xtr_data <= 64'h0123456789abcdef;
		end
		else if (xtr_valid && xtr_ready)
		begin
			xtr_last <= 1'b1;
			xtr_valid <= !xtr_last;
			xtr_data <= ~xtr_data;
		end
		else if (xtr_go && !xtr_valid && !xtr_last)
			xtr_valid <= 1'b1;
	end
	assign xtr_port = 1'b0;
	assign xtr_bytes = 3'h3;
endmodule : frame_dma_far_model
`default_nettype wire

// file: frame_dma_descriptor_engine_bench.sv
`timescale 1ns/1ps
`default_nettype none
module frame_dma_descriptor_engine_bench import frame_dma_pkg::*;;
	logic mclk, rst, hsel, hwrite, slow, xtr_go, hreadyout, hresp, mem_req, mem_we, mem_gnt;
	logic mem_rvalid, mem_rerr, inj_valid, inj_ready, inj_sof, inj_eof, inj_port;
	logic xtr_valid, xtr_port, xtr_last, xtr_ready, irq;
	logic [31:0] haddr, hwdata, hrdata, mem_addr, v;
	logic [63:0] mem_wdata, mem_rdata, inj_data, xtr_data;
	logic [5:0] mem_tag, mem_rtag;
	logic [7:0] inj_byte_en;
	logic [2:0] hsize, xtr_bytes;
	logic [1:0] htrans;
	wire logic hready;
	int failures, checked;
	assign hready = hreadyout;
	frame_dma_engine dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hresp, .hrdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_tag,
		.mem_gnt, .mem_rvalid, .mem_rtag, .mem_rdata, .mem_rerr, .inj_valid, .inj_ready,
		.inj_data, .inj_byte_en, .inj_sof, .inj_eof, .inj_port, .xtr_valid, .xtr_port,
		.xtr_data, .xtr_last, .xtr_bytes, .xtr_ready, .irq);
	frame_dma_far_model u_mem (.mclk, .rst, .slow, .xtr_go, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_tag, .mem_gnt, .mem_rvalid, .mem_rtag, .mem_rdata, .mem_rerr,
		.inj_valid, .inj_ready, .inj_data, .inj_byte_en, .inj_sof, .inj_eof, .inj_port,
		.xtr_valid, .xtr_port, .xtr_data, .xtr_last, .xtr_bytes, .xtr_ready);
	// 40 MHz clock
	always #12.5 mclk = ~mclk;
	task chk(input string n, input logic [79:0] s, input logic [79:0] e);
		checked++;
		if (s !== e)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// one single word transfer, read data lands in v
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge mclk);
		while (!hready) @(posedge mclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge mclk);
		while (!hready) @(posedge mclk);
		v = hrdata;
	endtask : bus
	task rc(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(n, v, e);
	endtask : rc
	task ram(input logic [31:0] a, input logic [63:0] d);
		u_mem.mem[a[31:3]] = d;
	endtask : ram
	function automatic logic [63:0] m(input logic [31:0] a);
		return u_mem.mem[a[31:3]];
	endfunction : m
	// bounded wait for the done flag of a status word; running out is a mismatch
	task wdone(input logic [31:0] a);
		logic [63:0] w;
		w = m(a);
		for (int i = 0; i < 3000 && w[ST_DONE] !== 1'b1; i++)
		begin
			@(posedge mclk);
			w = m(a);
		end
		chk("done flag", w[ST_DONE], 1'b1);
	endtask : wdone
	task final_report;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	// watchdog
	initial
	begin
		repeat (20000) @(posedge mclk);
		failures++;
		final_report();
	end
	// main sequence
	initial
	begin
		mclk = 1'b0;
		rst = 1'b1;
		{hsel, hwrite, slow, xtr_go, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		failures = 0;
		checked = 0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		rc("active", OFF_ACTIVE, 32'h0);
		rc("cfg", {GRP_CFG, 3'h0, 2'h0}, {26'h0, CFG_RESET});
		bus(1'b1, OFF_ACTIVE, 32'hff);
		rc("active ro", OFF_ACTIVE, 32'h0);
		rc("unmapped", 8'hfc, 32'h0);
		rc("vector", OFF_VECTOR, 32'h0);
		$display("test reset done");
		// injection: one entry, offset 3 length 5, then a zero length entry
		slow <= 1'b1;
		ram(32'h1000, 64'h1); // misaligned next ends chain
		ram(32'h1008, 64'h10040);
		ram(32'h1010, 64'h2000);
		ram(32'h1018, 64'h370005); // offset plus length fits
		ram(32'h1028, 64'h0);
		ram(32'h2000, 64'h1122334455667788);
		bus(1'b1, {GRP_HEAD, 3'h0, 2'h0}, 32'h1000);
		bus(1'b1, OFF_EN_DCB, 32'h1);
		bus(1'b1, OFF_EN_DB, 32'h1);
		bus(1'b1, OFF_EN_CH, 32'h1);
		bus(1'b1, OFF_ACTIVATE, 32'h1);
		wdone(32'h1018);
		chk("inj status", m(32'h1018), 64'h3f0005);
		chk("inj words", u_mem.inj_log.size(), 1);
		chk("inj word", u_mem.inj_log[0], {3'h3, 8'hf8, 64'h1122334455667788});
		rc("dcb event", OFF_EV_DCB, 32'h1);
		rc("db event", OFF_EV_DB, 32'h1);
		rc("vector", OFF_VECTOR, 32'h1);
		chk("irq", irq, 1'b1);
		rc("current", {GRP_CUR, 3'h0, 2'h0}, 32'h1000);
		rc("active", OFF_ACTIVE, 32'h1);
		rc("pending", OFF_PENDING, 32'h0);
		bus(1'b1, OFF_EV_DCB, 32'h1);
		bus(1'b1, OFF_EV_DB, 32'h1);
		rc("vector", OFF_VECTOR, 32'h0);
		chk("irq", irq, 1'b0);
		// extend the ended chain; the first block stays in memory
		ram(32'h1300, 64'h1);
		ram(32'h1310, 64'h2008);
		ram(32'h1318, 64'h30008);
		ram(32'h2008, 64'h99aabbccddeeff00);
		ram(32'h1000, 64'h1301);
		ram(32'h1000, 64'h1300);
		bus(1'b1, OFF_RELIST, 32'h1);
		wdone(32'h1318);
		chk("relist word", u_mem.inj_log[1], {3'h3, 8'hff, 64'h99aabbccddeeff00});
		chk("relist status", m(32'h1318), 64'hb0008);
		rc("current", {GRP_CUR, 3'h0, 2'h0}, 32'h1300);
		bus(1'b1, OFF_STOP, 32'h1);
		rc("active", OFF_ACTIVE, 32'h0);
		$display("test injection done");
		// extraction on channel 6, frame-end-only events, misaligned second entry
		ram(32'h1100, 64'h3);
		ram(32'h1108, 64'h80); // block size a multiple of 128
		ram(32'h1110, 64'h3000);
		ram(32'h1118, 64'h40000);
		ram(32'h1120, 64'h3001);
		bus(1'b1, {GRP_CFG, 3'h6, 2'h0}, 32'h12);
		bus(1'b1, {GRP_HEAD, 3'h6, 2'h0}, 32'h1100);
		bus(1'b1, OFF_EN_DB, 32'h40);
		bus(1'b1, OFF_EN_CH, 32'h40);
		bus(1'b1, OFF_ACTIVATE, 32'h40);
		xtr_go <= 1'b1;
		wdone(32'h1118);
		chk("xtr word0", m(32'h3000), 64'h0123456789abcdef);
		chk("xtr word1", m(32'h3008), 64'hfedcba9876543210);
		chk("xtr status", m(32'h1118), 64'hf000b);
		rc("db event", OFF_EV_DB, 32'h40);
		rc("vector", OFF_VECTOR, 32'h40);
		bus(1'b1, OFF_EV_DB, 32'h40);
		bus(1'b1, OFF_FORCE, 32'h40);
		rc("active", OFF_ACTIVE, 32'h0);
		$display("test extraction done");
		// misaligned head pointer raises an error event
		bus(1'b1, {GRP_HEAD, 3'h1, 2'h0}, 32'h1004);
		bus(1'b1, OFF_EN_CH, 32'h2);
		bus(1'b1, OFF_ACTIVATE, 32'h2);
		rc("err event", OFF_EV_ERR, 32'h2);
		rc("vector", OFF_VECTOR, 32'h2);
		chk("irq", irq, 1'b1);
		bus(1'b1, OFF_EV_ERR, 32'h2);
		rc("vector", OFF_VECTOR, 32'h0);
		$display("test error done");
		// two injection channels at once, channel 2 on port 1
		ram(32'h1400, 64'h1);
		ram(32'h1410, 64'h2000);
		ram(32'h1418, 64'h30008);
		ram(32'h1500, 64'h1);
		ram(32'h1510, 64'h2000);
		ram(32'h1518, 64'h370005);
		bus(1'b1, {GRP_CFG, 3'h2, 2'h0}, 32'h2f);
		bus(1'b1, {GRP_HEAD, 3'h3, 2'h0}, 32'h1400);
		bus(1'b1, {GRP_HEAD, 3'h2, 2'h0}, 32'h1500);
		bus(1'b1, OFF_ACTIVATE, 32'hc);
		wdone(32'h1518);
		chk("inj count", u_mem.inj_log.size(), 4);
		chk("first channel", u_mem.inj_log[2], {3'h3, 8'hff, 64'h1122334455667788});
		chk("second channel", u_mem.inj_log[3], {3'h7, 8'hf8, 64'h1122334455667788});
		rc("db event", OFF_EV_DB, 32'h4);
		$display("test priority done");
		final_report();
	end
endmodule : frame_dma_descriptor_engine_bench
`default_nettype wire
